// file: ulrx_pkg.sv
/*
  shared constants for the rxcmd status encoder: register map, field
  positions, reset values, bus widths and the fsm state encoding.
  assumes a wishbone classic master and a link that owns the ulpi clock.
*/
package ulrx_pkg;
  // wishbone geometry
  localparam int ULRX_AW = 8;
  localparam int ULRX_DW = 32;
  // register byte offsets
  localparam logic [7:0] ULRX_OFS_CTRL   = 8'h00;
  localparam logic [7:0] ULRX_OFS_IE_R   = 8'h04;
  localparam logic [7:0] ULRX_OFS_IE_F   = 8'h08;
  localparam logic [7:0] ULRX_OFS_STATUS = 8'h0c;
  localparam logic [7:0] ULRX_OFS_ABORTS = 8'h10;
  // control field positions
  localparam int ULRX_C_XCVR  = 0;
  localparam int ULRX_C_TERM  = 2;
  localparam int ULRX_C_OPM   = 3;
  localparam int ULRX_C_PDP   = 5;
  localparam int ULRX_C_PDM   = 6;
  localparam int ULRX_C_COMPL = 7;
  localparam int ULRX_C_EXT   = 8;
  localparam int ULRX_C_PASS  = 9;
  // interrupt enable bit positions
  localparam int ULRX_IE_HOST = 0;
  localparam int ULRX_IE_SV   = 1;
  localparam int ULRX_IE_SE   = 2;
  localparam int ULRX_IE_DISC = 3;
  // reset values
  localparam logic [9:0] ULRX_CTRL_RST = 10'h005;
  localparam logic [3:0] ULRX_IE_RST   = 4'hf;
  // ulpi codes and timing
  localparam logic [5:0] ULRX_EXT_ADDR = 6'h2f;
  localparam logic [2:0] ULRX_REG_EDGES = 3'h4;
  localparam int ULRX_SYNC_W = 22;
  // fsm states, one-hot
  typedef enum logic [3:0] {
    st_idle = 4'h1,
    st_turn = 4'h2,
    st_cmd  = 4'h4,
    st_rx   = 4'h8
  } ulrx_state_t;
endpackage : ulrx_pkg

// file: ulrx_sync.sv
/*
  two flip-flop synchroniser for a vector of independent levels.
  assumes each bit is a level that may change at any time; words are
  only sampled where the caller knows they are stable.
*/
`timescale 1ns/1ps
module ulrx_sync #(
  parameter int W = 1
) (
  // system
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst,
  // levels
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } ulrx_sync_st_t;

  ulrx_sync_st_t s;
  ulrx_sync_st_t next_s;

  // first stage feeds only the second stage
  always_comb begin
    next_s.meta = i_async;
    next_s.sync = s.meta;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_sync = s.sync;
endmodule : ulrx_sync

// file: ulrx_status.sv
/*
  rxcmd status encoder of a ulpi transceiver: line state, supply state
  and receive events are packed into rxcmd bytes and sent to the link.
  assumes the link drives the ulpi clock (sampled here) and the analogue
  front end gives plain levels; software configures over wishbone classic.
*/
`timescale 1ns/1ps
module ulrx_status (
  // system
  input  wire logic                          i_clk_sys,
  input  wire logic                          i_rst,
  // wishbone classic slave
  input  wire logic                          i_wb_cyc,
  input  wire logic                          i_wb_stb,
  input  wire logic                          i_wb_we,
  input  wire logic [ulrx_pkg::ULRX_AW-1:0]  i_wb_adr,
  input  wire logic [3:0]                    i_wb_sel,
  input  wire logic [ulrx_pkg::ULRX_DW-1:0]  i_wb_dat,
  output logic      [ulrx_pkg::ULRX_DW-1:0]  o_wb_dat,
  output logic                               o_wb_ack,
  // ulpi link side
  input  wire logic                          i_ulpi_clk,
  input  wire logic                          i_ulpi_stp,
  input  wire logic [7:0]                    i_ulpi_data,
  output logic      [7:0]                    o_ulpi_data,
  output logic                               o_ulpi_data_oe,
  output logic                               o_ulpi_dir,
  output logic                               o_ulpi_nxt,
  // analogue front end levels
  input  wire logic                          i_line_plus,
  input  wire logic                          i_line_minus,
  input  wire logic                          i_squelch,
  input  wire logic                          i_hs_diff,
  input  wire logic                          i_comp_session_end,
  input  wire logic                          i_comp_session_valid,
  input  wire logic                          i_comp_host_supply,
  input  wire logic                          i_fault,
  input  wire logic                          i_id,
  input  wire logic                          i_sync_found,
  input  wire logic                          i_rx_error,
  input  wire logic                          i_disconnect
);
  import ulrx_pkg::*;

  typedef struct packed {
    logic [9:0]  ctrl;
    logic [3:0]  ie_r;
    logic [3:0]  ie_f;
    ulrx_state_t st;
    logic        dir;
    logic        nxt;
    logic        oe;
    logic [7:0]  dout;
    logic        ack;
    logic [31:0] rdata;
    logic        clk_q;
    logic [3:0]  ind_q;
    logic [1:0]  ls_q;
    logic        pend;
    logic        reg_busy;
    logic [2:0]  reg_cnt;
    logic        ext_op;
    logic [7:0]  aborts;
    logic [7:0]  last_cmd;
  } ulrx_st_t;

  ulrx_st_t s;
  ulrx_st_t next_s;

  logic [ULRX_SYNC_W-1:0] sy;
  logic       s_clk, s_stp, s_plus, s_minus, s_sq, s_diff;
  logic       s_se, s_sv, s_hc, s_fault, s_id, s_sync, s_err, s_disc;
  logic [7:0] s_data;
  logic       ulpi_rise, host_mode, ext_ok, host_vld, chg, wb_take;
  logic [1:0] ls_now;
  logic [1:0] vbus_now;
  logic [3:0] ind_now;

  // every ulpi and front end pin level passes two flops before use
  ulrx_sync #(.W(ULRX_SYNC_W)) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_async   ({i_ulpi_clk, i_ulpi_stp, i_ulpi_data, i_line_plus, i_line_minus,
                 i_squelch, i_hs_diff, i_comp_session_end, i_comp_session_valid,
                 i_comp_host_supply, i_fault, i_id, i_sync_found, i_rx_error,
                 i_disconnect}),
    .o_sync    (sy)
  );

  assign {s_clk, s_stp, s_data, s_plus, s_minus, s_sq, s_diff, s_se, s_sv, s_hc,
          s_fault, s_id, s_sync, s_err, s_disc} = sy;

  // line state from the mode bits; fs and ls share the raw {dm,dp} map
  function automatic logic [1:0] enc_line(input logic [1:0] xcvr, input logic term,
                                          input logic [1:0] opm, input logic host,
                                          input logic dp, input logic dm,
                                          input logic sq, input logic diff);
    logic chirp;
    chirp = host ? (opm == 2'h2) : term;
    if (xcvr != 2'h0) begin
      enc_line = {dm, dp};
    end else if (sq) begin
      enc_line = 2'h0;
    end else if (chirp) begin
      enc_line = diff ? 2'h1 : 2'h2;
    end else begin
      enc_line = 2'h1;
    end
  endfunction : enc_line

  // supply state from the three indicators, highest first
  function automatic logic [1:0] enc_vbus(input logic hv, input logic sv, input logic se);
    if (hv) begin
      enc_vbus = 2'h3;
    end else if (sv) begin
      enc_vbus = 2'h2;
    end else if (!se) begin
      enc_vbus = 2'h1;
    end else begin
      enc_vbus = 2'h0;
    end
  endfunction : enc_vbus

  // whole rxcmd byte; disconnect is shown only outside a packet
  function automatic logic [7:0] rxcmd(input logic act, input logic err, input logic disc,
                                       input logic id, input logic [1:0] vb,
                                       input logic [1:0] ls);
    logic [1:0] ev;
    if (act) begin
      ev = err ? 2'h3 : 2'h1;
    end else begin
      ev = disc ? 2'h2 : 2'h0;
    end
    rxcmd = {1'b0, id, ev, vb, ls};
  endfunction : rxcmd

  // status sources
  assign ulpi_rise = s_clk & ~s.clk_q;
  assign host_mode = s.ctrl[ULRX_C_PDP] & s.ctrl[ULRX_C_PDM];
  assign ls_now    = enc_line(s.ctrl[ULRX_C_XCVR+:2], s.ctrl[ULRX_C_TERM],
                              s.ctrl[ULRX_C_OPM+:2], host_mode, s_plus, s_minus,
                              s_sq, s_diff);
  // external indicator means supply good unless the fault pin is active; without pass it also needs the comparator
  assign ext_ok    = ~(s_fault ^ s.ctrl[ULRX_C_COMPL]);
  assign host_vld  = s.ctrl[ULRX_C_EXT] ?
                     (ext_ok & (s.ctrl[ULRX_C_PASS] | s_hc)) : s_hc;
  assign vbus_now  = enc_vbus(host_vld, s_sv, s_se);
  assign ind_now   = {s_disc & host_mode, s_se, s_sv, host_vld};
  // edge-enabled changes plus any line change raise a pending rxcmd
  assign chg       = (|((ind_now & ~s.ind_q & s.ie_r) | (~ind_now & s.ind_q & s.ie_f)))
                     | (ls_now != s.ls_q);
  assign wb_take   = i_wb_cyc & i_wb_stb & ~s.ack;

  // next state: bus slave, change tracking and the ulpi turnaround fsm
  always_comb begin
    logic clr;
    clr = 1'b0;
    next_s = s;
    next_s.clk_q = s_clk;
    next_s.ls_q  = ls_now;
    next_s.ind_q = ind_now;
    next_s.ack   = wb_take;
    // read data is latched at the request edge and stands with ack
    if (wb_take) begin
      case (i_wb_adr)
        ULRX_OFS_CTRL:   next_s.rdata = {22'h0, s.ctrl};
        ULRX_OFS_IE_R:   next_s.rdata = {28'h0, s.ie_r};
        ULRX_OFS_IE_F:   next_s.rdata = {28'h0, s.ie_f};
        ULRX_OFS_STATUS: next_s.rdata = {19'h0, s.pend, s.ext_op, s.reg_busy,
                                         s.dir, (s.st == st_rx), s.last_cmd};
        ULRX_OFS_ABORTS: next_s.rdata = {24'h0, s.aborts};
        default:         next_s.rdata = 32'h0;
      endcase
      if (i_wb_we) begin
        case (i_wb_adr)
          ULRX_OFS_CTRL: begin
            if (i_wb_sel[0]) begin
              next_s.ctrl[7:0] = i_wb_dat[7:0];
            end
            if (i_wb_sel[1]) begin
              next_s.ctrl[9:8] = i_wb_dat[9:8];
            end
          end
          ULRX_OFS_IE_R: begin
            if (i_wb_sel[0]) begin
              next_s.ie_r = i_wb_dat[3:0];
            end
          end
          ULRX_OFS_IE_F: begin
            if (i_wb_sel[0]) begin
              next_s.ie_f = i_wb_dat[3:0];
            end
          end
          default: begin
            next_s.rdata = next_s.rdata;
          end
        endcase
      end
    end
    // link side moves only on a sampled ulpi clock rise
    if (ulpi_rise) begin
      case (s.st)
        st_idle: begin
          if (s_sync || s.pend) begin
            // taking the bus kills any register access in flight
            if (s.reg_busy) begin
              next_s.aborts   = s.aborts + 8'h01;
              next_s.reg_busy = 1'b0;
            end
            next_s.dir = 1'b1;
            next_s.oe  = 1'b0;
            if (s_sync) begin
              next_s.nxt = 1'b1;
              next_s.st  = st_rx;
            end else begin
              next_s.st  = st_turn;
            end
          end else if (!s.reg_busy) begin
            // txcmd of a register read or write starts an access
            if (s_data[7]) begin
              next_s.reg_busy = 1'b1;
              next_s.reg_cnt  = 3'h0;
              next_s.ext_op   = (s_data[5:0] == ULRX_EXT_ADDR);
            end
          end else if (s_stp || (s.reg_cnt == ULRX_REG_EDGES - 3'h1)) begin
            next_s.reg_busy = 1'b0;
          end else begin
            next_s.reg_cnt = s.reg_cnt + 3'h1;
          end
        end
        st_turn: begin
          next_s.oe       = 1'b1;
          next_s.dout     = rxcmd(1'b0, 1'b0, ind_now[ULRX_IE_DISC], s_id, vbus_now, ls_now);
          next_s.last_cmd = next_s.dout;
          next_s.st       = st_cmd;
          clr             = 1'b1;
        end
        st_cmd: begin
          // back-to-back updates reuse the turned bus
          if (s.pend) begin
            next_s.dout     = rxcmd(1'b0, 1'b0, ind_now[ULRX_IE_DISC], s_id, vbus_now,
                                    ls_now);
            next_s.last_cmd = next_s.dout;
            clr             = 1'b1;
          end else begin
            next_s.dir = 1'b0;
            next_s.oe  = 1'b0;
            next_s.st  = st_idle;
          end
        end
        st_rx: begin
          // nxt falls after the first rx period: no packet bytes pass through here
          next_s.nxt      = 1'b0;
          next_s.oe       = 1'b1;
          next_s.dout     = rxcmd(s_sync, s_err, ind_now[ULRX_IE_DISC], s_id, vbus_now,
                                  ls_now);
          next_s.last_cmd = next_s.dout;
          clr             = 1'b1;
          // rx active low is reported before dir falls
          if (!s_sync) begin
            next_s.st = st_cmd;
          end
        end
        default: begin
          next_s.st  = st_idle;
          next_s.dir = 1'b0;
          next_s.nxt = 1'b0;
          next_s.oe  = 1'b0;
        end
      endcase
    end
    // a change in the clearing cycle keeps the request alive
    next_s.pend = (s.pend & ~clr) | chg;
  end

  // single state register
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      s          <= '0;
      s.ctrl     <= ULRX_CTRL_RST;
      s.ie_r     <= ULRX_IE_RST;
      s.ie_f     <= ULRX_IE_RST;
      s.st       <= st_idle;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from flops
  assign o_wb_dat       = s.rdata;
  assign o_wb_ack       = s.ack;
  assign o_ulpi_data    = s.dout;
  assign o_ulpi_data_oe = s.oe;
  assign o_ulpi_dir     = s.dir;
  assign o_ulpi_nxt     = s.nxt;

  default clocking dc @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  // full-speed j with either role
  fs_line_j_a: assert property ((s.ctrl[1:0] == 2'h1) && s_plus && !s_minus
                                |-> ls_now == 2'h1)
    else $error("full-speed j not coded 01");
  // low-speed host k is plus line high
  ls_host_k_a: assert property ((s.ctrl[1:0] == 2'h2) && host_mode && s_plus && !s_minus
                                |-> ls_now == 2'h1)
    else $error("low-speed k not coded 01");
  // peripheral high-speed never shows invalid codes
  hs_periph_a: assert property ((s.ctrl[1:0] == 2'h0) && !s.ctrl[ULRX_C_TERM] && !host_mode
                                |-> ls_now == {1'b0, !s_sq})
    else $error("high-speed squelch coding wrong");
  // host in chirp opmode reports the differential receiver
  host_chirp_a: assert property ((s.ctrl[1:0] == 2'h0) && host_mode
                                 && (s.ctrl[4:3] == 2'h2) && !s_sq
                                 |-> ls_now == (s_diff ? 2'h1 : 2'h2))
    else $error("host chirp coding wrong");
  // comparators drive the low supply codes directly
  vbus_direct_a: assert property (!host_vld && s_sv |-> vbus_now == 2'h2)
    else $error("session valid not coded 10");
  // sync seen in idle raises dir and nxt on the same edge
  rx_start_a: assert property (ulpi_rise && (s.st == st_idle) && s_sync
                               |=> o_ulpi_dir && o_ulpi_nxt && (s.st == st_rx))
    else $error("rx start without dir and nxt");
  // error during rx: nxt low and error code in the byte
  rx_error_a: assert property (ulpi_rise && (s.st == st_rx) && s_sync && s_err
                               |=> !o_ulpi_nxt && (o_ulpi_data[5:4] == 2'h3))
    else $error("rx error not reported");
  // disconnect code never appears outside host mode
  disc_host_a: assert property (o_ulpi_data_oe && !host_mode && $stable(s.ctrl)
                                && $rose(o_ulpi_data_oe) |-> o_ulpi_data[5:4] != 2'h2)
    else $error("disconnect shown without host mode");
  // dir taken during register access counts one abort
  reg_abort_a: assert property (ulpi_rise && (s.st == st_idle) && s.reg_busy
                                && (s_sync || s.pend)
                                |=> (s.aborts == $past(s.aborts) + 8'h01) && !s.reg_busy)
    else $error("register abort not counted");
  // an enabled change gets dir within a few ulpi periods
  change_send_a: assert property (chg && (s.st == st_idle) && !s.dir && !s.reg_busy
                                  |-> ##[1:40] o_ulpi_dir)
    else $error("changed status not sent");
  // bus ack is a single-cycle pulse
  wb_ack_a: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");

  rx_pkt_c:   cover property (s.st == st_rx ##[1:200] s.st == st_cmd);
  rx_err_c:   cover property (o_ulpi_data_oe && o_ulpi_data[5:4] == 2'h3);
  abort_c:    cover property (s.aborts != 8'h00);
  cmd_send_c: cover property ($rose(o_ulpi_dir) && !o_ulpi_nxt);
endmodule : ulrx_status

// file: ulrx_link_model.sv
/*
  behavioural link controller on the far side of the ulpi: runs the ulpi
  clock, owns the data wire while dir is low, stores each rxcmd and makes
  register accesses that it retries after an abort.
  assumes the device changes dir, nxt and data once per ulpi period.
*/
`timescale 1ns/1ps
module ulrx_link_model (
  // ulpi
  output logic             o_ulpi_clk,
  output logic             o_ulpi_stp,
  output logic       [7:0] o_wire_data,
  input  wire logic  [7:0] i_dev_data,
  input  wire logic        i_dev_oe,
  input  wire logic        i_dir,
  input  wire logic        i_nxt,
  // register access request from the bench
  input  wire logic        i_req,
  input  wire logic  [7:0] i_cmd,
  output logic             o_busy,
  output logic             o_done,
  output logic       [7:0] o_retries,
  // stored status
  output logic       [7:0] o_last,
  output logic      [15:0] o_cnt,
  output logic             o_rx_active,
  output logic             o_seen_nxt,
  output logic             o_dropped
);
  logic [7:0] drv;
  logic [7:0] idle_pat;
  logic       dir_q;
  logic       link_oe;
  logic [2:0] steps;

  // free running clock; the odd offset keeps it out of phase with the system clock
  initial begin
    {o_ulpi_stp, o_busy, o_done, o_rx_active, o_seen_nxt, o_dropped, dir_q, link_oe} = 8'h00;
    {drv, o_retries, o_last, o_cnt, steps} = '0;
    idle_pat = 8'h5a;
    o_ulpi_clk = 1'b0;
    #13;
    forever #400 o_ulpi_clk = ~o_ulpi_clk;
  end

  // released wire shows a pattern that changes each period, never the last value
  assign o_wire_data = i_dev_oe ? i_dev_data : (link_oe ? drv : idle_pat);

  // bus ownership and register access
  always @(posedge o_ulpi_clk) begin
    idle_pat <= ~idle_pat;
    dir_q    <= i_dir;
    link_oe  <= ~i_dir; // link stays off the wire while the device owns it
    if (!i_req) o_done <= 1'b0;
    if (i_dir) begin
      drv        <= 8'h00;
      o_ulpi_stp <= 1'b0;
      if (o_busy) begin
        o_busy    <= 1'b0;
        o_retries <= o_retries + 8'h01;
      end
    end else if (o_busy) begin
      steps      <= steps + 3'h1;
      o_ulpi_stp <= (steps == 3'h2);
      if (steps == 3'h3) begin
        o_busy <= 1'b0;
        o_done <= 1'b1;
        drv    <= 8'h00;
      end
    end else if (i_req && !o_done) begin
      o_busy <= 1'b1;
      steps  <= 3'h0;
      drv    <= i_cmd;
    end
  end

  // rxcmd capture; a turnaround cycle with nxt high marks packet start
  always @(posedge o_ulpi_clk) begin
    if (i_dir && i_nxt && !dir_q) begin
      o_rx_active <= 1'b1;
      o_seen_nxt  <= 1'b1;
      o_dropped   <= 1'b0;
    end else if (i_dir && dir_q && i_dev_oe && !i_nxt) begin
      o_last      <= i_dev_data;
      o_cnt       <= o_cnt + 16'h0001;
      o_rx_active <= i_dev_data[4];
      if (i_dev_data[5:4] == 2'b11) o_dropped <= 1'b1;
    end
    if (!i_dir) o_rx_active <= 1'b0;
  end
endmodule : ulrx_link_model

// file: tb.sv
/*
  self-checking bench for the rxcmd status encoder: registers, line state
  tables, supply state, receive events, disconnect and register aborts.
  assumes ulrx_link_model supplies the ulpi clock and stores rxcmds.
*/
`timescale 1ns/1ps
module tb;
  import ulrx_pkg::*;
  logic        clk, rst, cyc, stb, we, ack, ucl, stp, oe, dir, nxt;
  logic [7:0]  adr, dout, wire_d, last, cmd, retries;
  logic [31:0] wdat, wbq, rdat;
  logic        plus, minus, sq, diff, se, sv, hv, fault, id, sync, err, disc;
  logic        req, done, busy, ract, seen, drop;
  logic [15:0] cnt;
  int          mismatches = 0;
  int          tests_run = 0;
  int          cycles = 0;

  ulrx_status dut_u (.i_clk_sys(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat), .o_wb_dat(wbq), .o_wb_ack(ack),
    .i_ulpi_clk(ucl), .i_ulpi_stp(stp), .i_ulpi_data(wire_d), .o_ulpi_data(dout),
    .o_ulpi_data_oe(oe), .o_ulpi_dir(dir), .o_ulpi_nxt(nxt), .i_line_plus(plus),
    .i_line_minus(minus), .i_squelch(sq), .i_hs_diff(diff), .i_comp_session_end(se),
    .i_comp_session_valid(sv), .i_comp_host_supply(hv), .i_fault(fault), .i_id(id),
    .i_sync_found(sync), .i_rx_error(err), .i_disconnect(disc));
  ulrx_link_model link_u (.o_ulpi_clk(ucl), .o_ulpi_stp(stp), .o_wire_data(wire_d),
    .i_dev_data(dout), .i_dev_oe(oe), .i_dir(dir), .i_nxt(nxt), .i_req(req), .i_cmd(cmd),
    .o_busy(busy), .o_done(done), .o_retries(retries), .o_last(last), .o_cnt(cnt),
    .o_rx_active(ract), .o_seen_nxt(seen), .o_dropped(drop));

  initial clk = 1'b0;
  always #50 clk = ~clk;

  // hang guard, over ten times the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic close_out;
    $display("checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // classic single cycle; read data taken at the ack edge only
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    rdat = wbq;
    {cyc, stb, we} <= 3'b000;
    if (n >= 40) chk("wb ack", 32'h1, 32'h0);
  endtask : wb

  // bus is quiet once dir stays low for three ulpi periods
  task automatic settle;
    int n, q;
    n = 0;
    q = 0;
    while (q < 3 && n < 80) begin
      @(posedge ucl);
      n++;
      q = (dir === 1'b0) ? q + 1 : 0;
    end
    chk("bus settles", 32'h1, 32'(n < 80));
  endtask : settle

  task automatic wait_flag(ref logic f);
    int n;
    n = 0;
    while (f !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk("model flag", 32'h1, 32'(f));
  endtask : wait_flag

  task automatic ls_case(input logic [9:0] c, input logic [3:0] in, input logic [1:0] e);
    wb(1'b1, ULRX_OFS_CTRL, {22'h0, c});
    @(posedge clk);
    {minus, plus, sq, diff} <= in;
    settle();
    chk("line state", 32'(e), 32'(last[1:0]));
  endtask : ls_case

  task automatic vb_case(input logic [3:0] in, input logic [1:0] e);
    @(posedge clk);
    {se, sv, hv, fault} <= in;
    settle();
    chk("supply state", 32'(e), 32'(last[3:2]));
  endtask : vb_case

  task automatic s_regs;
    wb(1'b0, ULRX_OFS_CTRL, 32'h0);
    chk("ctrl reset", {22'h0, ULRX_CTRL_RST}, rdat);
    wb(1'b0, ULRX_OFS_IE_R, 32'h0);
    chk("rise enable reset", {28'h0, ULRX_IE_RST}, rdat);
    wb(1'b0, ULRX_OFS_IE_F, 32'h0);
    chk("fall enable reset", {28'h0, ULRX_IE_RST}, rdat);
    wb(1'b1, ULRX_OFS_ABORTS, 32'hff);
    wb(1'b0, ULRX_OFS_ABORTS, 32'h0);
    chk("aborts read only", 32'h0, rdat);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped read", 32'h0, rdat);
    wb(1'b1, ULRX_OFS_CTRL, 32'hffff_ffff);
    wb(1'b0, ULRX_OFS_CTRL, 32'h0);
    chk("ctrl width", 32'h3ff, rdat);
  endtask : s_regs

  task automatic s_line;
    for (int i = 0; i < 4; i++) begin
      ls_case(10'h005, {2'(i), 2'b10}, 2'(i));
      ls_case(10'h066, {2'(i), 2'b10}, 2'(i));
    end
    ls_case(10'h065, 4'b1010, 2'b10);
    ls_case(10'h000, 4'b0010, 2'b00);
    ls_case(10'h000, 4'b0000, 2'b01);
    ls_case(10'h004, 4'b0001, 2'b01);
    ls_case(10'h004, 4'b0000, 2'b10);
    ls_case(10'h070, 4'b0001, 2'b01);
    ls_case(10'h070, 4'b0000, 2'b10);
    ls_case(10'h068, 4'b0000, 2'b01);
    ls_case(10'h078, 4'b0010, 2'b00);
    ls_case(10'h060, 4'b0001, 2'b01);
    ls_case(10'h005, 4'b0110, 2'b01);
  endtask : s_line

  task automatic s_vbus;
    logic [15:0] c0;
    wb(1'b1, ULRX_OFS_IE_R, 32'hf);
    wb(1'b1, ULRX_OFS_IE_F, 32'hf);
    vb_case(4'b1000, 2'b00);
    vb_case(4'b0000, 2'b01);
    vb_case(4'b0100, 2'b10);
    vb_case(4'b0110, 2'b11);
    vb_case(4'b0100, 2'b10);
    wb(1'b1, ULRX_OFS_IE_R, 32'h0);
    wb(1'b1, ULRX_OFS_IE_F, 32'h0);
    c0 = cnt;
    vb_case(4'b0110, 2'b10);
    vb_case(4'b0100, 2'b10);
    chk("masked supply rxcmds", 32'(c0), 32'(cnt));
    wb(1'b1, ULRX_OFS_IE_R, 32'hf);
    wb(1'b1, ULRX_OFS_IE_F, 32'hf);
    wb(1'b1, ULRX_OFS_CTRL, 32'h385);
    vb_case(4'b0101, 2'b11);
    vb_case(4'b0100, 2'b10);
    wb(1'b1, ULRX_OFS_CTRL, 32'h185);
    vb_case(4'b0101, 2'b10);
    vb_case(4'b0111, 2'b11);
    wb(1'b1, ULRX_OFS_CTRL, 32'h005);
    vb_case(4'b0100, 2'b10);
  endtask : s_vbus

  task automatic s_rx;
    @(posedge clk);
    sync <= 1'b1;
    wait_flag(ract);
    chk("rx start by dir and nxt", 32'h1, 32'(seen));
    repeat (3) @(posedge ucl);
    chk("rx active event", 32'h1, 32'(last[5:4]));
    @(posedge clk);
    err <= 1'b1;
    repeat (4) @(posedge ucl);
    chk("error event", 32'h3, 32'(last[5:4]));
    chk("nxt low on error", 32'h0, 32'(nxt));
    chk("packet dropped", 32'h1, 32'(drop));
    @(posedge clk);
    {sync, err} <= 2'b00;
    settle();
    chk("rx end event", 32'h0, 32'(last[5:4]));
    chk("rx active cleared", 32'h0, 32'(ract));
  endtask : s_rx

  task automatic s_disc;
    @(posedge clk);
    {id, disc} <= 2'b11;
    settle();
    chk("peripheral disconnect", 32'h0, 32'(last[5:4]));
    @(posedge clk);
    disc <= 1'b0;
    wb(1'b1, ULRX_OFS_CTRL, 32'h065);
    settle();
    @(posedge clk);
    disc <= 1'b1;
    settle();
    chk("host disconnect", 32'h2, 32'(last[5:4]));
    @(posedge clk);
    disc <= 1'b0;
    settle();
    chk("host reconnect", 32'h0, 32'(last[5:4]));
    chk("id and spare bit", 32'h1, 32'(last[7:6]));
  endtask : s_disc

  task automatic s_abort;
    wb(1'b1, ULRX_OFS_CTRL, 32'h005);
    settle();
    @(posedge clk);
    {cmd, req} <= {8'h96, 1'b1};
    wait_flag(busy);
    @(posedge clk);
    plus <= ~plus;
    wait_flag(done);
    @(posedge clk);
    req <= 1'b0;
    settle();
    wb(1'b0, ULRX_OFS_ABORTS, 32'h0);
    chk("abort count", 32'h1, rdat);
    chk("link retries", 32'h1, 32'(retries));
    wb(1'b0, ULRX_OFS_STATUS, 32'h0);
    chk("immediate access", 32'h0, 32'(rdat[11]));
    @(posedge clk);
    {cmd, req} <= {8'haf, 1'b1};
    wait_flag(done);
    @(posedge clk);
    req <= 1'b0;
    settle();
    wb(1'b0, ULRX_OFS_STATUS, 32'h0);
    chk("extended access", 32'h1, 32'(rdat[11]));
  endtask : s_abort

  // main sequence
  initial begin
    {rst, cyc, stb, we, req} = 5'b10000;
    {adr, wdat, cmd} = '0;
    {plus, minus, sq, diff, se, sv, hv, fault, id, sync, err, disc} = 12'b1010_0100_0000;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    s_regs();
    s_line();
    s_vbus();
    s_rx();
    s_disc();
    s_abort();
    close_out();
  end
endmodule : tb
